/* File: rtl/lcdseg_regs.sv */
// display data registers, generators, mux and pin logic of the segment lcd block
module lcdseg_regs import lcdseg_pkg::*; #(
	parameter logic [31:0] ID_VALUE = 32'h0001_0100, // arbitrary identity and revision
	parameter int LS_DIV = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// lcd drive towards gpio
	output logic [N_PINS-1:0] seg_out,
	output logic [N_COMS-1:0] com_out
);
	logic rst_sync1_ff, rst_sync2_ff;
	logic [31:0] div_ff, ctrl_ff, hrdata_ff, rd_val, rd_mask, wr_mask;
	logic [31:0] data_lo_ff [N_PORTS];
	logic [31:0] data_hi_ff [N_PORTS];
	logic wr_pend_ff, hreadyout_ff, take;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [CNT_W-1:0] ls_cnt_ff;
	logic ls_tick_ff;
	logic [CNT_W-1:0] gen_cnt [N_GEN];
	logic [1:0] gen_qtr [N_GEN];
	logic [COMNUM_W-1:0] gen_idx [N_GEN];
	logic gen_dead [N_GEN];
	logic [CNT_W-1:0] sub_div, dead_div;
	logic [COMNUM_W-1:0] com_num, sel_idx;
	logic sel_ls, sel_active, sel_dead;
	logic [N_PINS-1:0] nxt_seg;
	logic [N_COMS-1:0] seg_com_ff;
	logic [N_PINS-1:0] seg_out_ff;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mask of writable bits per address; zero for id and unmapped holes
	function automatic logic [31:0] wmask(input logic [ADDR_W-1:0] a);
		logic [31:0] m;
		m = '0;
		if (a[ADDR_W-1:GRP_LSB] == OFS_DATA_LO[ADDR_W-1:GRP_LSB] ||
			a[ADDR_W-1:GRP_LSB] == OFS_DATA_HI[ADDR_W-1:GRP_LSB]) begin
			m = FULL_MASK;
		end else if (a == OFS_DIV) begin
			m = FULL_MASK;
		end else if (a == OFS_CTRL) begin
			m = CTRL_MASK;
		end
		return m;
	endfunction

	assign take = hsel && htrans[HTRANS_ACT] && hready;
	assign rd_mask = wmask(haddr);
	assign wr_mask = wmask(wr_addr_ff);

	always_comb begin
		rd_val = '0;
		if (haddr[ADDR_W-1:GRP_LSB] == OFS_DATA_LO[ADDR_W-1:GRP_LSB]) begin
			rd_val = data_lo_ff[haddr[GRP_LSB-1:IDX_LSB]];
		end else if (haddr[ADDR_W-1:GRP_LSB] == OFS_DATA_HI[ADDR_W-1:GRP_LSB]) begin
			rd_val = data_hi_ff[haddr[GRP_LSB-1:IDX_LSB]];
		end else if (haddr == OFS_ID) begin
			rd_val = ID_VALUE;
		end else if (haddr == OFS_DIV) begin
			rd_val = div_ff;
		end else if (haddr == OFS_CTRL) begin
			rd_val = ctrl_ff;
		end
		// a read right behind a write to the same word sees the new value
		if (wr_pend_ff && wr_addr_ff == haddr) begin
			rd_val = (rd_val & ~rd_mask) | (hwdata & rd_mask);
		end
	end

	// zero wait states; narrow writes and unmapped words are ignored, answer okay
	always_ff @(posedge sys_clk or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			hrdata_ff <= '0;
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			wr_pend_ff <= take && hwrite && hsize == HSIZE_WORD;
			wr_addr_ff <= haddr;
			if (take && !hwrite) begin
				hrdata_ff <= rd_val;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			div_ff <= DIV_RST;
			ctrl_ff <= CTRL_RST;
			for (int p = 0; p < N_PORTS; p++) begin
				data_lo_ff[p] <= DATA_RST;
				data_hi_ff[p] <= DATA_RST;
			end
		end else if (wr_pend_ff) begin
			if (wr_addr_ff == OFS_DIV) begin
				div_ff <= hwdata & wr_mask;
			end
			if (wr_addr_ff == OFS_CTRL) begin
				ctrl_ff <= hwdata & wr_mask;
			end
			if (wr_addr_ff[ADDR_W-1:GRP_LSB] == OFS_DATA_LO[ADDR_W-1:GRP_LSB]) begin
				data_lo_ff[wr_addr_ff[GRP_LSB-1:IDX_LSB]] <= hwdata;
			end
			if (wr_addr_ff[ADDR_W-1:GRP_LSB] == OFS_DATA_HI[ADDR_W-1:GRP_LSB]) begin
				data_hi_ff[wr_addr_ff[GRP_LSB-1:IDX_LSB]] <= hwdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// slow generator tick; one clock only, the low-speed side runs on an enable
	always_ff @(posedge sys_clk or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			ls_cnt_ff <= '0;
			ls_tick_ff <= 1'b0;
		end else begin
			ls_tick_ff <= ls_cnt_ff == CNT_W'(LS_DIV - 1);
			ls_cnt_ff <= (ls_cnt_ff == CNT_W'(LS_DIV - 1)) ? '0 : ls_cnt_ff + 1'b1;
		end
	end

	assign sub_div = div_ff[DIV_SUB_LSB +: CNT_W];
	assign dead_div = div_ff[DIV_DEAD_LSB +: CNT_W];
	assign com_num = ctrl_ff[CTRL_COMNUM_LSB +: COMNUM_W];

	for (genvar g = 0; g < N_GEN; g++) begin : gen_engine
		logic [CNT_W-1:0] cnt_ff, limit;
		logic [1:0] qtr_ff;
		logic [COMNUM_W-1:0] idx_ff;
		logic dead_ff, tick, en;
		assign tick = (g == GEN_HS) ? 1'b1 : ls_tick_ff;
		assign en = ctrl_ff[CTRL_HS_EN + g];
		// dead time of D lasts 4*D ticks; D of zero means no dead time
		assign limit = dead_ff ? dead_div - 1'b1 : sub_div;
		always_ff @(posedge sys_clk or negedge rst_sync2_ff) begin
			if (!rst_sync2_ff) begin
				cnt_ff <= '0;
				qtr_ff <= '0;
				idx_ff <= '0;
				dead_ff <= 1'b0;
			end else if (!en) begin
				cnt_ff <= '0;
				qtr_ff <= '0;
				idx_ff <= '0;
				dead_ff <= 1'b0;
			end else if (tick) begin
				// compare with < so a shrunk divider never runs the counter round
				if (cnt_ff < limit) begin
					cnt_ff <= cnt_ff + 1'b1;
				end else begin
					cnt_ff <= '0;
					qtr_ff <= qtr_ff + 1'b1;
					if (qtr_ff == LAST_QTR) begin
						if (dead_ff) begin
							dead_ff <= 1'b0;
						end else if (idx_ff >= com_num) begin
							idx_ff <= '0;
							dead_ff <= dead_div != '0;
						end else begin
							idx_ff <= idx_ff + 1'b1;
						end
					end
				end
			end
		end
		assign gen_cnt[g] = cnt_ff;
		assign gen_qtr[g] = qtr_ff;
		assign gen_idx[g] = idx_ff;
		assign gen_dead[g] = dead_ff;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign sel_ls = ctrl_ff[CTRL_LS_SEL];
	assign sel_active = ctrl_ff[CTRL_HS_EN + int'(sel_ls)];
	assign sel_idx = gen_idx[sel_ls];
	assign sel_dead = gen_dead[sel_ls];

	for (genvar k = 0; k < N_PINS; k++) begin : gen_pin
		localparam int P = k / PINS_PER_PORT;
		localparam int N = k % PINS_PER_PORT;
		logic [FIELD_W-1:0] fld_lo, fld_hi;
		assign fld_lo = data_lo_ff[P][FIELD_W*N +: FIELD_W];
		assign fld_hi = data_hi_ff[P][FIELD_W*N +: FIELD_W];
		assign nxt_seg[k] = sel_idx[2] ? fld_hi[sel_idx[1:0]] : fld_lo[sel_idx[1:0]];
	end

	always_ff @(posedge sys_clk or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			seg_out_ff <= '0;
			seg_com_ff <= '0;
		end else if (!sel_active) begin
			seg_out_ff <= '0;
			seg_com_ff <= '0;
		end else if (sel_dead) begin
			seg_out_ff <= '1;
			seg_com_ff <= '1;
		end else begin
			seg_out_ff <= nxt_seg;
			seg_com_ff <= COM_ONE << sel_idx;
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_ff;
	assign seg_out = seg_out_ff;
	assign com_out = seg_com_ff;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync2_ff);

	sequence sq_wr_div;
		take && hwrite && hsize == HSIZE_WORD && haddr == OFS_DIV ##1 1'b1;
	endsequence
	sequence sq_hs_subframe_end;
		ctrl_ff[CTRL_HS_EN] && !gen_dead[GEN_HS] && !wr_pend_ff &&
			gen_cnt[GEN_HS] >= sub_div && gen_qtr[GEN_HS] == LAST_QTR &&
			gen_idx[GEN_HS] < com_num;
	endsequence

	AST_DIV_WRITE: assert property (sq_wr_div |=> div_ff == $past(hwdata))
		else $error("divider write not stored");
	AST_ID_READ: assert property (take && !hwrite && haddr == OFS_ID |=> hrdata_ff == ID_VALUE)
		else $error("identity read wrong");
	AST_DEAD_ONES: assert property (sel_active && sel_dead |=> seg_out == '1 && com_out == '1)
		else $error("dead time outputs not all ones");
	AST_SEG_LOW: assert property (sel_active && !sel_dead && !sel_idx[2]
		|=> seg_out[0] == $past(data_lo_ff[0][sel_idx[1:0]]))
		else $error("low group segment bit wrong");
	AST_SEG_HIGH: assert property (sel_active && !sel_dead && sel_idx[2]
		|=> seg_out[PINS_PER_PORT+5] == $past(data_hi_ff[1][FIELD_W*5 + sel_idx[1:0]]))
		else $error("high group segment bit wrong");
	// a pending control write moves com_num on the next edge, before the generator clears its index at sub-frame end
	AST_COM_BOUND: assert property (sel_active && sel_idx <= com_num && $stable(ctrl_ff)
		&& !wr_pend_ff |=> sel_idx <= com_num)
		else $error("common index beyond configured count");
	AST_SUB_COUNT: assert property (ctrl_ff[CTRL_HS_EN] && !gen_dead[GEN_HS] && !wr_pend_ff
		&& gen_cnt[GEN_HS] < sub_div |=> gen_cnt[GEN_HS] == $past(gen_cnt[GEN_HS]) + 1'b1)
		else $error("sub-frame counter did not advance");
	AST_SUB_END: assert property (sq_hs_subframe_end |=> gen_cnt[GEN_HS] == '0
		&& gen_idx[GEN_HS] == $past(gen_idx[GEN_HS]) + 1'b1)
		else $error("sub-frame end did not step common");
	AST_MUX_LS: assert property (sel_ls && sel_active && !gen_dead[GEN_LS]
		|=> com_out == COM_ONE << $past(gen_idx[GEN_LS]))
		else $error("low-speed generator not forwarded");
endmodule // lcdseg_regs

/* File: rtl/lcdseg_pkg.sv */
// constants and register map of the segment lcd display data block
// Overview of operation
// - eight virtual lcd ports, each with its own display data storage
// - every configured segment is one pin of a virtual lcd port
// - each display data register is 32 bits of segment-common on/off state
// - per port one register holds commons 0-3, a second commons 4-7
// - bits 4i+3..4i of a data register belong to port pin i
// - data registers are memory mapped, read and written over the ahb slave
// - divider register sets sub-frame period and dead-time period
// - control register configures high-speed and low-speed generators
// - read-only identity register reports block identity and revision
// - pin logic uses the selected sub-frame common to pick the stored bit
// - a multiplexer forwards the high-speed or low-speed generator outputs
// - sub-frame lasts 4*(C+1) generator ticks, using a 16-bit counter
// - during dead time after each frame all commons and segments are 1
package lcdseg_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_ID = 12'h000;
	localparam logic [11:0] OFS_DIV = 12'h004;
	localparam logic [11:0] OFS_CTRL = 12'h008;
	localparam logic [11:0] OFS_DATA_LO = 12'h100;
	localparam logic [11:0] OFS_DATA_HI = 12'h120;
	localparam int IDX_LSB = 2;
	localparam int GRP_LSB = 5;
	localparam int N_PORTS = 8;
	localparam int PINS_PER_PORT = 8;
	localparam int FIELD_W = 4;
	localparam int N_PINS = N_PORTS * PINS_PER_PORT;
	localparam int N_COMS = 8;
	localparam int CNT_W = 16;
	localparam int DIV_SUB_LSB = 0;
	localparam int DIV_DEAD_LSB = 16;
	localparam int CTRL_HS_EN = 0;
	localparam int CTRL_LS_SEL = 2;
	localparam int CTRL_COMNUM_LSB = 4;
	localparam int COMNUM_W = 3;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0077;
	localparam logic [31:0] DIV_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [31:0] FULL_MASK = 32'hFFFF_FFFF;
	localparam logic [1:0] LAST_QTR = 2'h3;
	localparam logic [7:0] COM_ONE = 8'h01;
	localparam int N_GEN = 2;
	localparam int GEN_HS = 0;
	localparam int GEN_LS = 1;
	localparam int HTRANS_ACT = 1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

/* File: verif/lcdseg_glass.sv */
// lcd glass model: reports each held common with its length and segment levels
module lcdseg_glass import lcdseg_pkg::*; (
	// clock and window
	input wire logic sys_clk,
	input wire logic watch,
	// drive from the block
	input wire logic [N_PINS-1:0] seg_out,
	input wire logic [N_COMS-1:0] com_out,
	// one report per finished hold
	output logic step_vld,
	output logic [7:0] step_com,
	output logic [15:0] step_len,
	output logic [N_PINS-1:0] step_seg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N_COMS-1:0] prev_com_ff;
	logic [N_PINS-1:0] prev_seg_ff;
	logic [15:0] len_ff;
	logic [1:0] chg_ff;
	// the first two changes are skipped: the first hold depends on enable phase
	always_ff @(posedge sys_clk) begin
		prev_com_ff <= com_out;
		prev_seg_ff <= seg_out;
		step_vld <= 1'b0;
		len_ff <= len_ff + 16'h1;
		if (!watch) chg_ff <= 2'h0;
		if (com_out !== prev_com_ff) begin
			len_ff <= 16'h1;
			if (watch && chg_ff != 2'h3) chg_ff <= chg_ff + 2'h1;
			step_vld <= watch && chg_ff >= 2'h2;
			step_com <= prev_com_ff;
			step_len <= len_ff;
			step_seg <= prev_seg_ff;
		end
	end
endmodule // lcdseg_glass

/* File: verif/test_lcdseg_regs.sv */
// self-checking bench of the segment lcd display data block
module test_lcdseg_regs import lcdseg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID_V = 32'h00A5_0102; // arbitrary identity value
	logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, watch = 1'b0, rd_dp = 1'b0;
	logic hready = 1'b1;
	logic [ADDR_W-1:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata, lf = 32'h0000_0045;
	logic hreadyout, hresp, step_vld;
	logic [N_PINS-1:0] seg_out, step_seg;
	logic [N_COMS-1:0] com_out;
	logic [7:0] step_com;
	logic [15:0] step_len;
	logic [31:0] shadow [2][8];
	logic [95:0] rdq [$], stq [$];
	int fail_count = 0, compares = 0, cyc = 0;
	lcdseg_regs #(.ID_VALUE(ID_V), .LS_DIV(8)) uut (.sys_clk(sys_clk), .rstn(rstn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .seg_out(seg_out), .com_out(com_out));
	lcdseg_glass glass (.sys_clk(sys_clk), .watch(watch), .seg_out(seg_out),
		.com_out(com_out), .step_vld(step_vld), .step_com(step_com),
		.step_len(step_len), .step_seg(step_seg));
	initial forever #50 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [63:0] exp_seg(input int c);
		for (int k = 0; k < 64; k++) exp_seg[k] = shadow[c/4][k/8][4*(k%8)+c%4];
	endfunction
	// zero-wait slave, so the address phase is held one edge only
	task automatic ahb(input logic [11:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= sz;
		@(posedge sys_clk);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ahb(a, 1'b1, HSIZE_WORD, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		rdq.push_back({64'h0, e});
		ahb(a, 1'b0, HSIZE_WORD, 32'h0);
	endtask
	// write then read of one word back to back: the read is taken in the write's data phase
	task automatic wrrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		rdq.push_back({64'h0, e});
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		hsize <= HSIZE_WORD;
		@(posedge sys_clk);
		hwrite <= 1'b0;
		hwdata <= d;
		@(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	task automatic run(input logic [31:0] ctrl, input int c, d, tick, ncom, n);
		int p;
		int l;
		l = ncom + (d > 0);
		for (int s = 0; s < n; s++) begin
			p = (1 + s) % l;
			if (p < ncom) stq.push_back({8'(1 << p), 16'(4*(c+1)*tick), 8'h0, exp_seg(p)});
			else stq.push_back({8'hFF, 16'(4*d*tick), 8'h0, {64{1'b1}}});
		end
		@(posedge sys_clk);
		watch <= 1'b1;
		wr(OFS_DIV, 32'((d << 16) | c));
		wr(OFS_CTRL, ctrl);
		for (int i = 0; i < 2000 && stq.size() > 0; i++) @(posedge sys_clk);
		watch <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		repeat (4) @(posedge sys_clk);
		chk({24'h0, com_out, seg_out}, 96'h0);
		chk(96'(stq.size()), 96'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		cyc++;
		if (rd_dp) chk({64'h0, hrdata}, rdq.pop_front());
		if (rd_dp) chk(96'(hresp), 96'(HRESP_OKAY));
		if (rd_dp) chk(96'(hreadyout), 96'h1);
		rd_dp <= hsel && htrans[1] && !hwrite && hready;
		if (step_vld && stq.size() > 0) chk({step_com, step_len, 8'h0, step_seg}, stq.pop_front());
		if (cyc > 5000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		shadow = '{default: 32'h0};
		repeat (3) @(posedge sys_clk);
		chk({23'h0, hreadyout, com_out, seg_out}, 96'h0);
		rstn <= 1'b1;
		for (int i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge sys_clk);
		rd(OFS_ID, ID_V);
		wr(OFS_ID, 32'h0);
		rd(OFS_ID, ID_V);
		rd(OFS_DIV, DIV_RST);
		rd(OFS_CTRL, CTRL_RST);
		rd(OFS_DATA_HI, DATA_RST);
		rd(12'h0FC, 32'h0);
		$display("test reset_id done");
		for (int g = 0; g < 2; g++) for (int p = 0; p < 8; p++) begin
			lf = lfsr(lf);
			shadow[g][p] = lf;
			wr((g ? OFS_DATA_HI : OFS_DATA_LO) + 12'(4*p), lf);
			rd((g ? OFS_DATA_HI : OFS_DATA_LO) + 12'(4*p), lf);
		end
		// byte writes are refused, so a half-written word never reaches the glass
		ahb(OFS_DATA_LO, 1'b1, 3'h0, 32'h0);
		rd(OFS_DATA_LO, shadow[0][0]);
		wr(12'h0FC, FULL_MASK);
		rd(12'h0FC, 32'h0);
		// a read straight behind a write to the same word must see the new data
		lf = lfsr(lf);
		shadow[1][7] = lf;
		wrrd(OFS_DATA_HI + 12'h01C, lf, lf);
		$display("test data_regs done");
		wr(OFS_CTRL, FULL_MASK);
		rd(OFS_CTRL, CTRL_MASK);
		// with hready low the address phase belongs to a stalled transfer and is not taken
		@(posedge sys_clk);
		hready <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		hready <= 1'b1;
		rd(OFS_CTRL, CTRL_MASK);
		wrrd(OFS_CTRL, FULL_MASK, CTRL_MASK);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_DIV, FULL_MASK);
		rd(OFS_DIV, FULL_MASK);
		$display("test config_regs done");
		run(32'h0000_0011, 1, 1, 1, 2, 5);
		$display("test fast_frames done");
		run(32'h0000_0076, 0, 0, 8, 8, 9);
		$display("test slow_frames done");
		conclude();
	end
endmodule // test_lcdseg_regs
